// ---- rtl/fcc_ctrl.sv ----
// Four-channel capture/compare control: registers, counter, compare and force logic
`timescale 1ns/10ps
module fcc_ctrl (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [15:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic special_mode,
   input wire logic [3:0] capture_event,
   input wire logic [3:0] flag_clear,
   output logic [7:0] bus_rdata,
   output logic [3:0] channel_event_flag,
   output logic [3:0] port_data,
   output logic [3:0] pin_level,
   output logic [3:0] pin_oe_n
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   logic [3:0] channel_function_select; // 1 = compare
   logic [3:0] ch3_compare_output_mask; // Channel 3 drive mask
   logic [3:0] ch3_compare_output_data; // Channel 3 data
   logic [7:0] output_control; // Mode/level pairs
   logic [15:0] count; // Free-running counter
   logic [7:0] timer_test_register; // Test bits
   logic [15:0] channel_value_register [4]; // Per-channel values
   logic [7:0] offset; // Register offset
   logic hit; // Address inside either window
   logic wr; // Decoded write
   logic [3:0] force_action_bit; // Force pulse this cycle
   logic [3:0] match; // Successful compare
   logic [3:0] fire; // Action fires
   logic ch3_fire; // Channel 3 compare fires
   logic [7:0] next_rdata; // Read mux

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   // Either base selects the same registers
   always_comb begin
      offset = bus_addr[7:0];
      hit = ((bus_addr & fcc_pkg::BASE_MASK) == fcc_pkg::BASE_BLOCKING)
         || ((bus_addr & fcc_pkg::BASE_MASK) == fcc_pkg::BASE_NONBLOCKING);
      wr = hit && bus_wr;
   end

   // Value register index from offset, hi byte at even offset
   function automatic logic [1:0] val_index(input logic [7:0] ofs);
      logic [7:0] d;
      d = ofs - fcc_pkg::OFS_VALUE_BASE;
      return d[2:1];
   endfunction : val_index

   // Offset lies within value registers
   function automatic logic is_value(input logic [7:0] ofs);
      return (ofs >= fcc_pkg::OFS_VALUE_BASE) && (ofs < fcc_pkg::OFS_TIMER_TEST);
   endfunction : is_value

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         channel_function_select <= fcc_pkg::RST_SELECT;
         ch3_compare_output_mask <= fcc_pkg::RST_MASK;
         ch3_compare_output_data <= fcc_pkg::RST_DATA;
         output_control <= fcc_pkg::RST_OUTPUT_CONTROL;
      end else if (wr) begin
         unique case (offset)
            fcc_pkg::OFS_CHANNEL_FUNCTION_SELECT: channel_function_select <= bus_wdata[3:0];
            fcc_pkg::OFS_CH3_COMPARE_OUTPUT_MASK: ch3_compare_output_mask <= bus_wdata[3:0];
            fcc_pkg::OFS_CH3_COMPARE_OUTPUT_DATA: ch3_compare_output_data <= bus_wdata[3:0];
            fcc_pkg::OFS_OUTPUT_CONTROL: output_control <= bus_wdata;
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // Force pulse, never stored
   // ----------------------------------------
   always_comb begin
      force_action_bit = (wr && offset == fcc_pkg::OFS_COMPARE_FORCE) ? bus_wdata[3:0] : 4'h0;
   end

   // ----------------------------------------
   // Counter and test register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         count <= fcc_pkg::RST_COUNT;
      end else if (wr && special_mode && offset == fcc_pkg::OFS_COUNT_HI) begin
         count[15:8] <= bus_wdata;
      end else if (wr && special_mode && offset == fcc_pkg::OFS_COUNT_LO) begin
         count[7:0] <= bus_wdata;
      end else begin
         count <= count + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         timer_test_register <= fcc_pkg::RST_TEST;
      end else if (wr && special_mode && offset == fcc_pkg::OFS_TIMER_TEST) begin
         timer_test_register <= bus_wdata & (8'h01 << fcc_pkg::TEST_BYPASS_BIT);
      end
   end

   // ----------------------------------------
   // Channel value registers
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            channel_value_register[i] <= fcc_pkg::RST_VALUE;
         end
      end else begin
         for (int i = 0; i < 4; i++) begin
            // Capture mode latches the counter on an edge event
            if (!channel_function_select[i] && capture_event[i]) begin
               channel_value_register[i] <= count;
            end else if (wr && is_value(offset) && val_index(offset) == 2'(i)
                         && channel_function_select[i]) begin
               if (offset[0] == 1'b0) begin
                  channel_value_register[i][15:8] <= bus_wdata;
               end else begin
                  channel_value_register[i][7:0] <= bus_wdata;
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Compare detection and fire
   // ----------------------------------------
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         match[i] = channel_function_select[i] && (count == channel_value_register[i]);
      end
      fire = (match | force_action_bit) & channel_function_select;
      ch3_fire = fire[fcc_pkg::CH3];
   end

   // ----------------------------------------
   // Event flags: set by compare or capture, forced suppresses
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         channel_event_flag <= 4'h0;
      end else begin
         // Set wins over clear; force masks the set
         channel_event_flag <= (channel_event_flag & ~flag_clear)
            | (match & ~force_action_bit)
            | (capture_event & ~channel_function_select);
      end
   end

   // ----------------------------------------
   // Timer port data register
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         port_data <= 4'h0;
      end else if (ch3_fire) begin
         port_data <= (port_data & ~ch3_compare_output_mask)
            | (ch3_compare_output_data & ch3_compare_output_mask);
      end
   end

   // ----------------------------------------
   // Per-channel output action
   // ----------------------------------------
   for (genvar g = 0; g < 4; g++) begin : g_ch
      fcc_channel_action u_act (
         .mclk(mclk),
         .resetn(resetn),
         .is_compare(channel_function_select[g]),
         .fire(fire[g]),
         .action(output_control[2*g+1:2*g]),
         .ch3_own(ch3_compare_output_mask[g]),
         .ch3_fire(ch3_fire),
         .ch3_level(ch3_compare_output_data[g]),
         .pin_level(pin_level[g]),
         .pin_oe_n(pin_oe_n[g])
      );
   end

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      if (hit && bus_rd) begin
         if (is_value(offset)) begin
            next_rdata = offset[0] ? channel_value_register[val_index(offset)][7:0]
                                   : channel_value_register[val_index(offset)][15:8];
         end else begin
            unique case (offset)
               fcc_pkg::OFS_CHANNEL_FUNCTION_SELECT: next_rdata = {4'h0, channel_function_select};
               fcc_pkg::OFS_COMPARE_FORCE: next_rdata = 8'h00;
               fcc_pkg::OFS_CH3_COMPARE_OUTPUT_MASK: next_rdata = {4'h0, ch3_compare_output_mask};
               fcc_pkg::OFS_CH3_COMPARE_OUTPUT_DATA: next_rdata = {4'h0, ch3_compare_output_data};
               fcc_pkg::OFS_COUNT_HI: next_rdata = count[15:8];
               fcc_pkg::OFS_COUNT_LO: next_rdata = count[7:0];
               fcc_pkg::OFS_OUTPUT_CONTROL: next_rdata = output_control;
               fcc_pkg::OFS_EVENT_FLAGS: next_rdata = {4'h0, channel_event_flag};
               fcc_pkg::OFS_TIMER_TEST: next_rdata = timer_test_register;
               default: next_rdata = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_rdata <= 8'h00;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_force_wr;
      wr && offset == fcc_pkg::OFS_COMPARE_FORCE;
   endsequence

   a_force_reads_zero: assert property (@(posedge mclk) disable iff (!resetn)
      (hit && bus_rd && offset == fcc_pkg::OFS_COMPARE_FORCE) |=> bus_rdata == 8'h00)
      else $error("force register read not zero");

   a_force_no_flag: assert property (@(posedge mclk) disable iff (!resetn)
      (s_force_wr ##0 (bus_wdata[0] && channel_function_select[0] && !flag_clear[0]
       && !channel_event_flag[0]))
      |=> !channel_event_flag[0])
      else $error("forced compare set flag");

   a_match_sets_flag: assert property (@(posedge mclk) disable iff (!resetn)
      (match[2] && !force_action_bit[2]) |=> channel_event_flag[2])
      else $error("compare did not set flag");

   a_force_beats_match: assert property (@(posedge mclk) disable iff (!resetn)
      (s_force_wr ##0 (bus_wdata[3] && match[3] && !channel_event_flag[3]))
      |=> !channel_event_flag[3])
      else $error("forced compare lost to real compare");

   a_ch3_port_copy: assert property (@(posedge mclk) disable iff (!resetn)
      ch3_fire |=> ((port_data & $past(ch3_compare_output_mask))
                   == ($past(ch3_compare_output_data) & $past(ch3_compare_output_mask))))
      else $error("channel 3 data not copied");

   a_ch3_override: assert property (@(posedge mclk) disable iff (!resetn)
      (ch3_fire && channel_function_select[0] && ch3_compare_output_mask[0])
      |=> pin_level[0] == $past(ch3_compare_output_data[0]))
      else $error("channel 3 override lost");

   a_force_acts: assert property (@(posedge mclk) disable iff (!resetn)
      (s_force_wr ##0 (bus_wdata[2] && channel_function_select[2]
       && !ch3_fire && output_control[5:4] == 2'b11)) |=> pin_level[2])
      else $error("forced set not applied");

   a_capture_drive_off: assert property (@(posedge mclk) disable iff (!resetn)
      !channel_function_select[1] |=> pin_oe_n[1])
      else $error("capture channel driving pin");

   a_mask_drives_pin: assert property (@(posedge mclk) disable iff (!resetn)
      (channel_function_select[0] && ch3_compare_output_mask[0]) |=> !pin_oe_n[0])
      else $error("masked compare pin not output");

   a_count_locked: assert property (@(posedge mclk) disable iff (!resetn)
      (!special_mode && wr && offset == fcc_pkg::OFS_COUNT_HI)
      |=> count == $past(count) + 16'h0001)
      else $error("counter written outside special mode");
endmodule : fcc_ctrl

// ---- inc/fcc_pkg.sv ----
// Package: register map, field layout and encodings of the capture/compare control block
package fcc_pkg;
   // Bases in the global address space
   localparam logic [15:0] BASE_BLOCKING = 16'h0200;
   localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
   localparam logic [15:0] BASE_MASK = 16'hff00;
   // Register offsets
   localparam logic [7:0] OFS_CHANNEL_FUNCTION_SELECT = 8'h20;
   localparam logic [7:0] OFS_COMPARE_FORCE = 8'h21;
   localparam logic [7:0] OFS_CH3_COMPARE_OUTPUT_MASK = 8'h22;
   localparam logic [7:0] OFS_CH3_COMPARE_OUTPUT_DATA = 8'h23;
   localparam logic [7:0] OFS_COUNT_HI = 8'h24;
   localparam logic [7:0] OFS_COUNT_LO = 8'h25;
   localparam logic [7:0] OFS_OUTPUT_CONTROL = 8'h28;
   localparam logic [7:0] OFS_EVENT_FLAGS = 8'h2c;
   localparam logic [7:0] OFS_VALUE_BASE = 8'h2e;
   localparam logic [7:0] OFS_TIMER_TEST = 8'h36;
   // Reset values
   localparam logic [3:0] RST_SELECT = 4'h0;
   localparam logic [3:0] RST_MASK = 4'h0;
   localparam logic [3:0] RST_DATA = 4'h0;
   localparam logic [7:0] RST_OUTPUT_CONTROL = 8'h00;
   localparam logic [15:0] RST_COUNT = 16'h0000;
   localparam logic [15:0] RST_VALUE = 16'h0000;
   localparam logic [7:0] RST_TEST = 8'h00;
   // Field positions
   localparam int CH3 = 3;
   localparam int TEST_BYPASS_BIT = 1;
   // Output action encoding {output_mode_bit, output_level_bit}
   typedef enum logic [1:0] {
      ACT_DISCONNECT = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_CLEAR = 2'b10,
      ACT_SET = 2'b11
   } fcc_action_t;
endpackage : fcc_pkg

// ---- rtl/fcc_channel_action.sv ----
// One channel's compare output action: pin level and drive enable
`timescale 1ns/10ps
module fcc_channel_action (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic is_compare,
   input wire logic fire,
   input wire logic [1:0] action,
   input wire logic ch3_own,
   input wire logic ch3_fire,
   input wire logic ch3_level,
   output logic pin_level,
   output logic pin_oe_n
);
   // ----------------------------------------
   // Pin level
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_level <= 1'b0;
      end else if (is_compare && ch3_own && ch3_fire) begin
         // Channel 3 data overrides own action
         pin_level <= ch3_level;
      end else if (is_compare && fire) begin
         unique case (fcc_pkg::fcc_action_t'(action))
            fcc_pkg::ACT_DISCONNECT: pin_level <= pin_level;
            fcc_pkg::ACT_TOGGLE: pin_level <= ~pin_level;
            fcc_pkg::ACT_CLEAR: pin_level <= 1'b0;
            fcc_pkg::ACT_SET: pin_level <= 1'b1;
         endcase
      end
   end

   // ----------------------------------------
   // Drive enable, low while driving
   // ----------------------------------------
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pin_oe_n <= 1'b1;
      end else begin
         // Driven only in compare mode, by mask or by own action bits other than disconnect
         pin_oe_n <= ~(is_compare && (ch3_own || (action != 2'b00)));
      end
   end
endmodule : fcc_channel_action

// ---- verification/four_channel_capture_compare_ctrl_tb_top.sv ----
// Testbench: register-level scenarios for the capture/compare control block
`timescale 1ns/10ps
module four_channel_capture_compare_ctrl_tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic mclk = 1'b0; // 10 MHz clock
   logic resetn = 1'b0; // Active low reset
   logic [15:0] bus_addr = 16'h0000; // Global address
   logic bus_wr = 1'b0; // Write strobe
   logic bus_rd = 1'b0; // Read strobe
   logic [7:0] bus_wdata = 8'h00; // Write data
   logic special_mode = 1'b0; // Chip mode level
   logic [3:0] capture_event = 4'h0; // Capture pulses
   logic [3:0] flag_clear = 4'h0; // Flag clear pulses
   logic [7:0] bus_rdata; // Read data
   logic [3:0] channel_event_flag; // Event flags
   logic [3:0] port_data; // Timer port data
   logic [3:0] pin_level; // Compare output lines
   logic [3:0] pin_oe_n; // Pin drive enables, low = drive
   int bad_count = 0; // Mismatches
   int tests_run = 0; // Comparisons made
   int i; // Loop and wait counter
   logic [1:0] acts [5] = '{2'b11, 2'b01, 2'b01, 2'b10, 2'b00}; // Action sequence
   logic [7:0] rst_ofs [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h28, 8'h2c, 8'h36}; // Reset reads
   logic lv; // Expected channel 2 line
   // ------------------------------------------------------------
   // Design and clock
   // ------------------------------------------------------------
   fcc_ctrl u_fcc_ctrl (.mclk(mclk), .resetn(resetn), .bus_addr(bus_addr), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_wdata(bus_wdata), .special_mode(special_mode),
      .capture_event(capture_event), .flag_clear(flag_clear), .bus_rdata(bus_rdata),
      .channel_event_flag(channel_event_flag), .port_data(port_data),
      .pin_level(pin_level), .pin_oe_n(pin_oe_n));
   // Free-running clock
   always #50 mclk = ~mclk;
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   // Compare one value, report a mismatch
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One byte write at a full address
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge mclk);
      bus_addr = a;
      bus_wdata = d;
      bus_wr = 1'b1;
      @(negedge mclk);
      bus_wr = 1'b0;
   endtask : wr
   // One byte read at a full address, checked against expectation
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge mclk);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge mclk);
      bus_rd = 1'b0;
      chk(bus_rdata, exp);
   endtask : rd
   // Register write through the blocking window
   task automatic rw(input logic [7:0] o, input logic [7:0] d);
      wr({fcc_pkg::BASE_BLOCKING[15:8], o}, d);
   endtask : rw
   // Register read through the blocking window
   task automatic rr(input logic [7:0] o, input logic [7:0] exp);
      rd({fcc_pkg::BASE_BLOCKING[15:8], o}, exp);
   endtask : rr
   // Verdict and end of run
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(negedge mclk);
      resetn = 1'b1;
      // Reset values and drive enables
      foreach (rst_ofs[k]) rr(rst_ofs[k], 8'h00);
      chk({4'h0, pin_oe_n}, 8'h0f);
      // Both windows decode, force reads zero, unmapped reads zero
      wr({fcc_pkg::BASE_NONBLOCKING[15:8], 8'h20}, 8'h0f);
      rr(8'h20, 8'h0f);
      rw(8'h21, 8'h0f);
      rr(8'h21, 8'h00);
      rr(8'h3f, 8'h00);
      // Every output action on channel 2 through the force register
      lv = 1'b0;
      foreach (acts[k]) begin
         rw(8'h28, {2'b00, acts[k], 4'h0});
         rw(8'h21, 8'h04);
         case (acts[k])
            2'b01: lv = ~lv; // Toggle
            2'b10: lv = 1'b0; // Clear
            2'b11: lv = 1'b1; // Set
            default: lv = lv; // Disconnected, line holds
         endcase
         chk({7'h0, pin_level[2]}, {7'h0, lv});
         chk({7'h0, pin_oe_n[2]}, {7'h0, acts[k] == 2'b00});
         chk({4'h0, channel_event_flag}, 8'h00);
      end
      // Channel 2 as capture: force does nothing, value writes ignored
      rw(8'h20, 8'h0b);
      rw(8'h28, 8'h30);
      rw(8'h21, 8'h04);
      chk({6'h0, pin_level[2], pin_oe_n[2]}, 8'h01);
      rw(8'h32, 8'h55);
      rr(8'h32, 8'h00);
      rw(8'h20, 8'h0f);
      rw(8'h32, 8'h55);
      rr(8'h32, 8'h55);
      // Forced channel 3 drives masked channels from its data
      rw(8'h21, 8'h04);
      chk({7'h0, pin_level[2]}, 8'h01);
      rw(8'h22, 8'h05);
      rw(8'h23, 8'h01);
      rw(8'h28, 8'hc0);
      rw(8'h21, 8'h08);
      chk({5'h0, pin_level[2:0]}, 8'h01);
      chk({4'h0, port_data}, 8'h01);
      chk({5'h0, pin_oe_n[2:0]}, 8'h02);
      chk({4'h0, channel_event_flag}, 8'h00);
      // Real compare on channels 2 and 3 at the same count
      rw(8'h28, 8'he0);
      rw(8'h23, 8'h04);
      special_mode = 1'b1;
      rw(8'h24, 8'h12);
      rw(8'h25, 8'h00);
      special_mode = 1'b0;
      rw(8'h32, 8'h12);
      rw(8'h33, 8'h40);
      rw(8'h34, 8'h12);
      rw(8'h35, 8'h40);
      chk({4'h0, channel_event_flag}, 8'h00);
      for (i = 0; i < 300 && channel_event_flag[3] !== 1'b1; i++) @(negedge mclk);
      if (i == 300) begin
         bad_count++;
         $display("[ERR] %0t: compare flag never set", $time);
      end
      @(negedge mclk);
      chk({4'h0, channel_event_flag}, 8'h0c);
      chk({5'h0, pin_level[2:0]}, 8'h04);
      chk({4'h0, port_data}, 8'h04);
      rr(8'h2c, 8'h0c);
      // Counter and test register locked outside special mode
      rw(8'h24, 8'h80);
      rr(8'h24, 8'h12);
      rw(8'h36, 8'h02);
      rr(8'h36, 8'h00);
      // Flag clearing and a capture on channel 1
      @(negedge mclk);
      flag_clear = 4'hf;
      @(negedge mclk);
      flag_clear = 4'h0;
      chk({4'h0, channel_event_flag}, 8'h00);
      rw(8'h20, 8'h0d);
      @(negedge mclk);
      capture_event = 4'h2;
      @(negedge mclk);
      capture_event = 4'h0;
      chk({4'h0, channel_event_flag}, 8'h02);
      rr(8'h30, 8'h12);
      // Test register opens in special mode; force and real compare on channel 3 together
      special_mode = 1'b1;
      rw(8'h36, 8'hff);
      rw(8'h24, 8'h12);
      rw(8'h25, 8'h3f);
      special_mode = 1'b0;
      rw(8'h21, 8'h08);
      chk({4'h0, channel_event_flag}, 8'h06);
      rr(8'h36, 8'h02);
      report_and_stop();
   end
endmodule : four_channel_capture_compare_ctrl_tb_top
